//--- core/eeprom_program_erase_control.sv
// Program/erase control, protection and security lock for the array.
// Assumes the CPU bus port below, the nonvolatile byte presented on
// nv_byte_i by the array, and the pump and cells outside this block.
`timescale 1ns/1ps
//
// Contract
// - Locked: no program/erase of secure bytes
// - Locked: block and bulk erase disabled
// - Locked: nonvolatile register not programmable
// - Locked: plain bytes still byte-erasable, readable
// - Locked: secure writes not latched, qualify nothing
// - Lock permanent, configuration frozen
// - Pump clock select: 1 bus, 0 RC
// - Power-down bit disables array, reset clears
// - Mode field selects program or erase kind
// - Protected block: no program or erase
// - Latch captures bus, held while enable set
// - Enable drives pump only after valid write
// - Clearing both bits clears enable only
// - Reset copies nonvolatile byte into shadow
// - Lock bit reads 0 when armed, sticky
// - Wait mode leaves operation running
// - Stop drops high voltage, resumes after
// - Four 128-byte blocks, one protect each
// - Any protect bit set blocks bulk erase
// - Mode frozen while enable set
// - Protect changes apply on reset or read
module eeprom_program_erase_control
   import eeprom_pe_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 8
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [DATA_W-1:0] nv_byte_i,
   input wire logic stop_i,
   output logic [DATA_W-1:0] rd_data_o,
   output logic hv_enable_o,
   output logic pump_clock_select_o,
   output logic array_power_down_o,
   output logic [1:0] op_mode_o,
   output logic [ADDR_W-1:0] op_addr_o,
   output logic [DATA_W-1:0] op_data_o,
   output logic op_target_nv_o,
   output logic lock_active_o
);

   // Elaboration stops on widths the decode cannot serve
   if (ADDR_W != 16 || DATA_W != 8) begin : gen_width_check
      $error("Only a 16-bit address and 8-bit data are served");
   end

   logic pump_clock_select;
   logic array_power_down;
   pe_mode_t mode_sel;
   logic bus_latch;
   logic program_enable;
   logic write_seen;
   logic [ADDR_W-1:0] lat_addr;
   logic [DATA_W-1:0] lat_data;
   logic lat_nv;
   logic [DATA_W-1:0] shadow;
   logic lock_armed;
   logic reload_pending;
   logic [DATA_W-1:0] rd_data;
   logic hv_enable;

   logic in_array;
   logic in_secure;
   logic is_nv;
   logic valid_array_write;
   logic ctl_wr;
   logic nv_rd;
   logic [1:0] blk_idx;
   logic blk_prot;
   logic op_allowed;
   logic next_hv;
   logic [DATA_W-1:0] ctl_value;
   logic [DATA_W-1:0] shadow_value;

   // Address decode
   always_comb begin
      in_array = 1'b0;
      in_secure = 1'b0;
      is_nv = 1'b0;
      if (addr_i >= ARRAY_FIRST && addr_i <= ARRAY_LAST) begin
         in_array = 1'b1;
         if (addr_i >= SECURE_FIRST && addr_i <= SECURE_LAST) begin
            in_secure = 1'b1;
         end
      end else if (addr_i == NV_ADDR) begin
         is_nv = 1'b1;
      end
   end

   // Latch stops following the bus once high voltage may be on
   assign valid_array_write = wr_i && bus_latch && !program_enable &&
      ((in_array && !(lock_armed && in_secure)) ||
       (is_nv && !lock_armed));

   // Control writes wait for a valid array write once latched
   assign ctl_wr = wr_i && addr_i == CTL_ADDR &&
      !(bus_latch && !write_seen);
   assign nv_rd = rd_i && is_nv;

   // Block from latched offset
   assign blk_idx = lat_addr[BLOCK_SHIFT+1:BLOCK_SHIFT];
   assign blk_prot = shadow[NV_BP_LO + 32'(blk_idx)];

   always_comb begin
      op_allowed = 1'b0;
      case (mode_sel)
         MODE_BYTE_PROG,
         MODE_BYTE_ERASE: begin
            if (lat_nv) begin
               op_allowed = !lock_armed;
            end else begin
               op_allowed = !blk_prot;
            end
         end
         MODE_BLOCK_ERASE: begin
            op_allowed = !lock_armed && !lat_nv && !blk_prot;
         end
         MODE_BULK_ERASE: begin
            op_allowed = !lock_armed && !lat_nv &&
               shadow[NV_BP_LO+NUM_BLOCKS-1:NV_BP_LO] == BP_NONE;
         end
         default: begin
            op_allowed = 1'b0;
         end
      endcase
   end

   // No wait input: an operation simply runs on through wait
   assign next_hv = program_enable && write_seen && op_allowed &&
      !stop_i;

   // Clock and power bits
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pump_clock_select <= 1'b0;
         array_power_down <= 1'b0;
      end else if (ctl_wr) begin
         pump_clock_select <= wr_data_i[CTL_PUMP_CLK];
         array_power_down <= wr_data_i[CTL_PWR_DOWN];
      end
   end

   // Mode field
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_sel <= MODE_BYTE_PROG;
      end else if (ctl_wr && !program_enable) begin
         mode_sel <= pe_mode_t'(wr_data_i[CTL_MODE_HI:CTL_MODE_LO]);
      end
   end

   // Latch and program enable
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bus_latch <= 1'b0;
         program_enable <= 1'b0;
      end else if (ctl_wr) begin
         // Latch stays while enable was set, letting the voltage fall
         bus_latch <= wr_data_i[CTL_LATCH] || program_enable;
         program_enable <= wr_data_i[CTL_PGM] &&
            bus_latch && write_seen;
      end
   end

   // Captured address and data
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         write_seen <= 1'b0;
         lat_addr <= '0;
         lat_data <= BYTE_ZERO;
         lat_nv <= 1'b0;
      end else if (valid_array_write) begin
         write_seen <= 1'b1;
         lat_addr <= addr_i;
         lat_data <= wr_data_i;
         lat_nv <= is_nv;
      end else if (!bus_latch) begin
         write_seen <= 1'b0;
      end
   end

   // Shadow loads after reset release and on each read of the byte
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reload_pending <= 1'b1;
         shadow <= SHADOW_RESET;
      end else if (reload_pending || nv_rd) begin
         reload_pending <= 1'b0;
         shadow <= nv_byte_i;
      end else if (wr_i && addr_i == SHADOW_ADDR && !lock_armed) begin
         // Frozen once the lock is armed
         shadow <= wr_data_i;
      end
   end

   // Lock only ever arms; cleared nv bit cannot be erased again
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lock_armed <= 1'b0;
      end else if ((reload_pending || nv_rd) && !nv_byte_i[NV_LOCK]) begin
         lock_armed <= 1'b1;
      end
   end

   always_comb begin
      ctl_value = BYTE_ZERO;
      ctl_value[CTL_PUMP_CLK] = pump_clock_select;
      ctl_value[CTL_PWR_DOWN] = array_power_down;
      ctl_value[CTL_MODE_HI:CTL_MODE_LO] = mode_sel;
      ctl_value[CTL_LATCH] = bus_latch;
      ctl_value[CTL_PGM] = program_enable;
      shadow_value = shadow;
      // Reflects the real lock, so a shadow write cannot fake it
      shadow_value[NV_LOCK] = !lock_armed;
   end

   // Read port, data in the following cycle only
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_data <= BYTE_ZERO;
      end else if (rd_i) begin
         if (addr_i == CTL_ADDR) begin
            rd_data <= ctl_value;
         end else if (addr_i == NV_ADDR) begin
            rd_data <= nv_byte_i;
         end else if (addr_i == SHADOW_ADDR) begin
            rd_data <= shadow_value;
         end else begin
            rd_data <= BYTE_ZERO;
         end
      end else begin
         rd_data <= BYTE_ZERO;
      end
   end

   // High voltage, one cycle behind the enable
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hv_enable <= 1'b0;
      end else begin
         hv_enable <= next_hv;
      end
   end

   assign rd_data_o = rd_data;
   assign hv_enable_o = hv_enable;
   assign pump_clock_select_o = pump_clock_select;
   assign array_power_down_o = array_power_down;
   assign op_mode_o = mode_sel;
   assign op_addr_o = lat_addr;
   assign op_data_o = lat_data;
   assign op_target_nv_o = lat_nv;
   assign lock_active_o = lock_armed;

   secure_refuse_a: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      wr_i && bus_latch && in_secure && lock_armed
      |=> $stable(lat_addr) && $stable(write_seen))
      else $error("secure write was latched");

   block_bulk_off_a: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      lock_armed && mode_sel[1] |=> !hv_enable)
      else $error("block or bulk erase ran while locked");

   nv_locked_a: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      lock_armed && lat_nv |=> !hv_enable)
      else $error("nonvolatile byte altered while locked");

   plain_byte_open_a: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      wr_i && bus_latch && !program_enable && lock_armed &&
      in_array && !in_secure
      |=> write_seen && lat_addr == $past(addr_i))
      else $error("plain byte not latched while locked");

   pump_select_a: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      ctl_wr |=> pump_clock_select_o == $past(wr_data_i[CTL_PUMP_CLK]))
      else $error("pump clock select not written");

   protect_block_a: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      blk_prot && !lat_nv |=> !hv_enable)
      else $error("protected block received high voltage");

   latch_hold_a: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      program_enable |=> bus_latch)
      else $error("latch cleared while enable set");

   pgm_qualify_a: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      $rose(program_enable) |-> $past(bus_latch && write_seen))
      else $error("enable set without a valid write");

   both_clear_a: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      ctl_wr && program_enable && !wr_data_i[CTL_LATCH] &&
      !wr_data_i[CTL_PGM]
      |=> !program_enable && bus_latch)
      else $error("double clear did not leave latch set");

   stop_drop_a: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      stop_i |=> !hv_enable)
      else $error("high voltage on during stop");

   stop_resume_a: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      $fell(stop_i) && program_enable && write_seen && op_allowed
      |=> hv_enable)
      else $error("high voltage did not resume after stop");

   lock_sticky_a: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      lock_armed |=> lock_armed && !shadow_value[NV_LOCK])
      else $error("lock bit returned to one");

   bulk_protect_a: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      mode_sel == MODE_BULK_ERASE && shadow[NV_BP_LO+NUM_BLOCKS-1:NV_BP_LO]
      != BP_NONE |=> !hv_enable)
      else $error("bulk erase with a block protected");

   mode_freeze_a: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      program_enable |=> $stable(mode_sel))
      else $error("mode changed while enable set");

   reload_a: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      nv_rd |=> shadow == $past(nv_byte_i))
      else $error("shadow not reloaded on read");

   power_down_a: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      ctl_wr |=> array_power_down_o == $past(wr_data_i[CTL_PWR_DOWN]))
      else $error("power-down bit not written");

   latch_capture_a: assert property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      valid_array_write |=> op_addr_o == $past(addr_i) &&
      op_data_o == $past(wr_data_i))
      else $error("valid write not captured");

   byte_prog_c: cover property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      hv_enable && mode_sel == MODE_BYTE_PROG);

   bulk_erase_c: cover property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      hv_enable && mode_sel == MODE_BULK_ERASE);

   stop_break_c: cover property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      program_enable && stop_i ##1 program_enable && !stop_i);

   lock_erase_c: cover property (
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      lock_armed && hv_enable && mode_sel == MODE_BYTE_ERASE);

endmodule

//--- core/eeprom_pe_pkg.sv
// Constants for the array program/erase controller.
// Assumes a 16-bit CPU address bus and 8-bit data bus.
package eeprom_pe_pkg;
   // Register port addresses
   localparam logic [15:0] CTL_ADDR = 16'h0040;
   localparam logic [15:0] NV_ADDR = 16'h0041;
   localparam logic [15:0] SHADOW_ADDR = 16'h0042;
   // Array map
   localparam logic [15:0] ARRAY_FIRST = 16'h0800;
   localparam logic [15:0] ARRAY_LAST = 16'h09FF;
   localparam logic [15:0] SECURE_FIRST = 16'h08F0;
   localparam logic [15:0] SECURE_LAST = 16'h08FF;
   localparam int BLOCK_SHIFT = 7;
   localparam int NUM_BLOCKS = 4;
   // Control register fields
   localparam int CTL_PUMP_CLK = 7;
   localparam int CTL_PWR_DOWN = 5;
   localparam int CTL_MODE_HI = 4;
   localparam int CTL_MODE_LO = 3;
   localparam int CTL_LATCH = 2;
   localparam int CTL_PGM = 0;
   // Nonvolatile and shadow fields
   localparam int NV_RSVD = 7;
   localparam int NV_LOCK = 4;
   localparam int NV_BP_LO = 0;
   localparam logic [7:0] SHADOW_RESET = 8'h1F;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [3:0] BP_NONE = 4'h0;
   typedef enum logic [1:0] {
      MODE_BYTE_PROG = 2'h0,
      MODE_BYTE_ERASE = 2'h1,
      MODE_BLOCK_ERASE = 2'h2,
      MODE_BULK_ERASE = 2'h3
   } pe_mode_t;
endpackage

//--- bench/nv_array_model.sv
// Behavioural model of the nonvolatile configuration byte in the array.
// Assumes it is driven by the controller's operation outputs.
`timescale 1ns/1ps
module nv_array_model
   import eeprom_pe_pkg::*;
#(
   parameter logic [7:0] INIT = 8'h70
) (
   input wire logic sys_clk_i,
   input wire logic hv_enable_i,
   input wire logic target_nv_i,
   input wire logic [1:0] mode_i,
   input wire logic [7:0] data_i,
   output logic [7:0] nv_byte_o
);
   // No reset: contents must survive system reset
   initial nv_byte_o = INIT;
   always @(posedge sys_clk_i) begin
      if (hv_enable_i && target_nv_i) begin
         case (mode_i)
            MODE_BYTE_PROG: nv_byte_o <= nv_byte_o & data_i;
            MODE_BYTE_ERASE: nv_byte_o <= 8'hFF;
            default: nv_byte_o <= nv_byte_o;
         endcase
      end
   end
endmodule

//--- bench/eeprom_program_erase_control_tb_top.sv
// Self-checking bench for the program/erase controller.
// Assumes the nonvolatile byte model beside it; reads checked via queue.
`timescale 1ns/1ps
module eeprom_program_erase_control_tb_top;
   import eeprom_pe_pkg::*;
   logic sys_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic stop_i = 1'b0;
   logic [15:0] addr_i = 16'h0000;
   logic [7:0] wr_data_i = 8'h00;
   logic [7:0] nv_byte, rd_data_o, op_data_o;
   logic [15:0] op_addr_o;
   logic [1:0] op_mode_o;
   logic hv_enable_o, pump_clock_select_o, array_power_down_o;
   logic op_target_nv_o, lock_active_o, rd_seen = 1'b0;
   logic [7:0] exp_q[$];
   logic [31:0] lfsr = 32'h966CCEAF;
   int miscompares = 0;
   int comparisons = 0;

   eeprom_program_erase_control eeprom_program_erase_control_i (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
      .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
      .nv_byte_i(nv_byte), .stop_i(stop_i), .rd_data_o(rd_data_o),
      .hv_enable_o(hv_enable_o), .pump_clock_select_o(pump_clock_select_o),
      .array_power_down_o(array_power_down_o), .op_mode_o(op_mode_o),
      .op_addr_o(op_addr_o), .op_data_o(op_data_o),
      .op_target_nv_o(op_target_nv_o), .lock_active_o(lock_active_o));
   nv_array_model nv_array_model_i (
      .sys_clk_i(sys_clk_i), .hv_enable_i(hv_enable_o),
      .target_nv_i(op_target_nv_o), .mode_i(op_mode_o),
      .data_i(op_data_o), .nv_byte_o(nv_byte));

   always #50 sys_clk_i = ~sys_clk_i;

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask

   // Expected value queued now, compared when the data appear
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      exp_q.push_back(e);
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
   endtask

   always @(posedge sys_clk_i) begin
      rd_seen <= rd_i;
      if (rd_seen) chk({8'h00, rd_data_o}, {8'h00, exp_q.pop_front()});
   end

   task automatic run_op(input logic [1:0] m, input logic [15:0] a,
                         input logic [7:0] d);
      wr(CTL_ADDR, {3'h0, m, 3'h4});
      wr(a, d);
      wr(CTL_ADDR, {3'h0, m, 3'h5});
      settle(2);
   endtask

   task automatic finish_op(input logic [1:0] m);
      wr(CTL_ADDR, {3'h0, m, 3'h4});
      settle(2);
      wr(CTL_ADDR, 8'h00);
   endtask

   task automatic do_reset;
      @(posedge sys_clk_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      settle(2);
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk_i);
      miscompares++;
      end_of_test();
   end

   initial begin
      logic [15:0] a;
      logic [7:0] d;
      repeat (20) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      settle(2);
      chk({15'h0, hv_enable_o}, 16'h0000);
      chk({15'h0, lock_active_o}, 16'h0000);
      rd(CTL_ADDR, 8'h00);
      rd(SHADOW_ADDR, 8'h70);
      // Bus clock at 10 MHz may drive the pump
      wr(CTL_ADDR, 8'hA0);
      settle(1);
      chk({15'h0, pump_clock_select_o}, 16'h0001);
      chk({15'h0, array_power_down_o}, 16'h0001);
      rd(CTL_ADDR, 8'hA0);
      wr(CTL_ADDR, 8'h00);
      settle(4);
      chk({15'h0, array_power_down_o}, 16'h0000);
      wr(CTL_ADDR, 8'h01);
      settle(2);
      chk({15'h0, hv_enable_o}, 16'h0000);
      for (int m = 0; m < 4; m++) begin
         lfsr = lfsr_next(lfsr);
         a = 16'h0900 | {8'h00, lfsr[7:0]};
         d = lfsr[15:8];
         run_op(m[1:0], a, d);
         chk({14'h0, op_mode_o}, {14'h0, m[1:0]});
         chk(op_addr_o, a);
         chk({8'h00, op_data_o}, {8'h00, d});
         chk({15'h0, hv_enable_o}, 16'h0001);
         wr(CTL_ADDR, {3'h0, ~m[1:0], 3'h5});
         settle(1);
         chk({14'h0, op_mode_o}, {14'h0, m[1:0]});
         if (m == 1) begin
            @(posedge sys_clk_i);
            stop_i <= 1'b1;
            settle(2);
            chk({15'h0, hv_enable_o}, 16'h0000);
            rd(CTL_ADDR, 8'h0D);
            stop_i <= 1'b0;
            settle(2);
            chk({15'h0, hv_enable_o}, 16'h0001);
            settle(2);
         end
         wr(CTL_ADDR, 8'h00);
         settle(2);
         chk({15'h0, hv_enable_o}, 16'h0000);
         rd(CTL_ADDR, {3'h0, m[1:0], 3'h4});
         wr(CTL_ADDR, 8'h00);
      end
      // Protect block 0 through the nonvolatile byte
      run_op(MODE_BYTE_ERASE, NV_ADDR, 8'h00);
      chk({15'h0, op_target_nv_o}, 16'h0001);
      finish_op(MODE_BYTE_ERASE);
      run_op(MODE_BYTE_PROG, NV_ADDR, 8'h71);
      finish_op(MODE_BYTE_PROG);
      run_op(MODE_BYTE_PROG, 16'h0810, 8'h5A);
      chk({15'h0, hv_enable_o}, 16'h0001);
      finish_op(MODE_BYTE_PROG);
      rd(NV_ADDR, 8'h71);
      rd(SHADOW_ADDR, 8'h71);
      run_op(MODE_BYTE_PROG, 16'h0810, 8'h5A);
      chk({15'h0, hv_enable_o}, 16'h0000);
      finish_op(MODE_BYTE_PROG);
      run_op(MODE_BLOCK_ERASE, 16'h0820, 8'h00);
      chk({15'h0, hv_enable_o}, 16'h0000);
      finish_op(MODE_BLOCK_ERASE);
      run_op(MODE_BULK_ERASE, 16'h0900, 8'h00);
      chk({15'h0, hv_enable_o}, 16'h0000);
      finish_op(MODE_BULK_ERASE);
      // Arm the lock, reserved bit kept zero
      run_op(MODE_BYTE_ERASE, NV_ADDR, 8'h00);
      finish_op(MODE_BYTE_ERASE);
      run_op(MODE_BYTE_PROG, NV_ADDR, 8'h60);
      finish_op(MODE_BYTE_PROG);
      do_reset();
      chk({15'h0, lock_active_o}, 16'h0001);
      wr(SHADOW_ADDR, 8'h1F);
      rd(SHADOW_ADDR, 8'h60);
      run_op(MODE_BYTE_ERASE, 16'h08EF, 8'h00);
      chk({15'h0, hv_enable_o}, 16'h0001);
      finish_op(MODE_BYTE_ERASE);
      run_op(MODE_BLOCK_ERASE, 16'h0880, 8'h00);
      chk({15'h0, hv_enable_o}, 16'h0000);
      finish_op(MODE_BLOCK_ERASE);
      run_op(MODE_BULK_ERASE, 16'h0880, 8'h00);
      chk({15'h0, hv_enable_o}, 16'h0000);
      finish_op(MODE_BULK_ERASE);
      wr(CTL_ADDR, 8'h04);
      wr(16'h0870, 8'h11);
      wr(16'h08F0, 8'h22);
      settle(1);
      chk(op_addr_o, 16'h0870);
      wr(CTL_ADDR, 8'h00);
      // Secure write leaves the latch stuck; reset recovers it
      run_op(MODE_BYTE_PROG, 16'h08F0, 8'h00);
      chk({15'h0, hv_enable_o}, 16'h0000);
      rd(CTL_ADDR, 8'h04);
      do_reset();
      chk({15'h0, lock_active_o}, 16'h0001);
      run_op(MODE_BYTE_ERASE, NV_ADDR, 8'h00);
      chk({15'h0, hv_enable_o}, 16'h0000);
      chk({8'h00, nv_byte}, 16'h0060);
      do_reset();
      settle(2);
      end_of_test();
   end
endmodule
